// ==== design/obcfg_pkg.sv ====
// option byte decoder constants, carriers and state layout
package obcfg_pkg;

  localparam logic [7:0]  READOUT_OPEN_CODE = 8'hAA;
  localparam logic [7:0]  BOOT_NONE      = 8'h00;
  localparam logic [7:0]  BOOT_ONE       = 8'h01;
  localparam logic [7:0]  BOOT_TWO       = 8'h02;
  localparam logic [7:0]  BOOT_THREE     = 8'h03;
  localparam logic [7:0]  BOOT_ALL_FROM  = 8'h7F;
  localparam int          PAGE_COUNT     = 128;
  localparam logic [7:0]  BOOT_ALL_PAGES = 8'h80;

  // bit positions inside the watchdog / fast oscillator byte and the slow oscillator byte
  localparam int          INDEP_HW_BIT   = 0;
  localparam int          INDEP_LP_BIT   = 1;
  localparam int          WINDOW_HW_BIT  = 2;
  localparam int          WINDOW_LP_BIT  = 3;
  localparam int          FAST_CNT_LSB   = 4;
  localparam int          SLOW_CNT_LSB   = 0;

  localparam int          SETTLE_W       = 13;
  localparam logic [1:0]  SETTLE_CODE_1  = 2'h0;
  localparam logic [1:0]  SETTLE_CODE_16 = 2'h1;
  localparam logic [1:0]  SETTLE_CODE_512 = 2'h2;
  localparam logic [12:0] SETTLE_1       = 13'h0001;
  localparam logic [12:0] SETTLE_16      = 13'h0010;
  localparam logic [12:0] SETTLE_512     = 13'h0200;
  localparam logic [12:0] SETTLE_4096    = 13'h1000;
  localparam int          OSC_FAST       = 0;
  localparam int          OSC_SLOW       = 1;

  typedef struct packed {
    logic [7:0] readout_protect_option;
    logic [7:0] boot_area_size_option;
    logic [7:0] reserved_option;
    logic [7:0] watchdog_hse_option;
    logic [7:0] lse_stabilize_option;
  } obcfg_opt_t;

  typedef struct packed {
    logic hw_start;
    logic lowpower;
  } obcfg_wdog_t;

  typedef enum logic [0:0] {
    OBCFG_LOADING,
    OBCFG_READY
  } obcfg_phase_t;

  typedef struct packed {
    obcfg_phase_t          phase;
    obcfg_opt_t            opt;
    logic [1:0]            osc_meta;
    logic [1:0]            osc_sync;
    logic [1:0]            osc_prev;
    logic [1:0]            osc_ready;
    logic [1:0][12:0]      osc_cnt;
    logic                  halt_prev;
    logic                  indep_freeze;
    logic                  window_stop;
    logic                  window_reset;
    logic [PAGE_COUNT-1:0] wr_protect;
  } obcfg_state_t;

  localparam obcfg_state_t STATE_RESET = '0;

endpackage : obcfg_pkg

// ==== design/obcfg_decoder.sv ====
// option byte decoder: latches option bytes in reset, decodes protection, watchdog and oscillator settle
`timescale 1ns/100ps
module obcfg_decoder #(
  parameter int PAGES = obcfg_pkg::PAGE_COUNT
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire obcfg_pkg::obcfg_opt_t i_opt,
  input  wire logic                  i_prog_unlocked,
  input  wire logic                  i_halt_mode,
  input  wire logic [1:0]            i_osc_en,
  input  wire logic [1:0]            i_osc_clk,
  output logic                       o_cfg_valid,
  output obcfg_pkg::obcfg_opt_t      o_opt_readback,
  output logic                       o_readout_unprotected,
  output logic [7:0]                 o_boot_pages,
  output logic [PAGES-1:0]           o_page_wr_protect,
  output obcfg_pkg::obcfg_wdog_t     o_indep_wdog,
  output obcfg_pkg::obcfg_wdog_t     o_window_wdog,
  output logic                       o_indep_wdog_freeze,
  output logic                       o_window_wdog_stop,
  output logic                       o_window_wdog_reset,
  output logic [1:0]                 o_osc_ready
);

  initial begin
    if (PAGES != obcfg_pkg::PAGE_COUNT) begin
      $error("page count must match the boot area decode");
    end
  end

  obcfg_pkg::obcfg_state_t st_r;
  obcfg_pkg::obcfg_state_t st_nxt;
  logic [7:0]              boot_pages;
  logic [PAGES-1:0]        prot_nxt;
  logic [1:0][12:0]        settle_target;
  logic [1:0][1:0]         settle_code;
  logic                    valid;

  assign valid = (st_r.phase == obcfg_pkg::OBCFG_READY);

  // boot area size to number of protected pages
  always_comb begin
    case (st_r.opt.boot_area_size_option)
      obcfg_pkg::BOOT_NONE:  boot_pages = obcfg_pkg::BOOT_NONE;
      obcfg_pkg::BOOT_ONE:   boot_pages = obcfg_pkg::BOOT_ONE;
      obcfg_pkg::BOOT_TWO:   boot_pages = obcfg_pkg::BOOT_TWO;
      obcfg_pkg::BOOT_THREE: boot_pages = obcfg_pkg::BOOT_THREE;
      default: begin
        if (st_r.opt.boot_area_size_option >= obcfg_pkg::BOOT_ALL_FROM) begin
          boot_pages = obcfg_pkg::BOOT_ALL_PAGES;
        end else begin
          boot_pages = st_r.opt.boot_area_size_option;
        end
      end
    endcase
  end

  // per page: boot area always locked, rest follows the unlock keys
  genvar gp;
  generate
    for (gp = 0; gp < PAGES; gp++) begin : g_page
      assign prot_nxt[gp] = (8'(gp) < boot_pages) ? 1'b1 : ~i_prog_unlocked;
    end
  endgenerate

  assign settle_code[obcfg_pkg::OSC_FAST] = st_r.opt.watchdog_hse_option[obcfg_pkg::FAST_CNT_LSB +: 2];
  assign settle_code[obcfg_pkg::OSC_SLOW] = st_r.opt.lse_stabilize_option[obcfg_pkg::SLOW_CNT_LSB +: 2];

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      case (settle_code[k])
        obcfg_pkg::SETTLE_CODE_1:   settle_target[k] = obcfg_pkg::SETTLE_1;
        obcfg_pkg::SETTLE_CODE_16:  settle_target[k] = obcfg_pkg::SETTLE_16;
        obcfg_pkg::SETTLE_CODE_512: settle_target[k] = obcfg_pkg::SETTLE_512;
        default:                    settle_target[k] = obcfg_pkg::SETTLE_4096;
      endcase
    end
  end

  always_comb begin
    st_nxt           = st_r;
    st_nxt.osc_meta  = i_osc_clk;
    st_nxt.osc_sync  = st_r.osc_meta;
    st_nxt.osc_prev  = st_r.osc_sync;
    st_nxt.halt_prev = i_halt_mode;
    case (st_r.phase)
      obcfg_pkg::OBCFG_LOADING: st_nxt.phase = obcfg_pkg::OBCFG_READY;
      obcfg_pkg::OBCFG_READY:   st_nxt.phase = obcfg_pkg::OBCFG_READY;
      default:                  st_nxt.phase = obcfg_pkg::OBCFG_LOADING;
    endcase
    st_nxt.wr_protect   = prot_nxt;
    st_nxt.indep_freeze = valid & i_halt_mode & st_r.opt.watchdog_hse_option[obcfg_pkg::INDEP_LP_BIT];
    st_nxt.window_stop  = valid & i_halt_mode & ~st_r.opt.watchdog_hse_option[obcfg_pkg::WINDOW_LP_BIT];
    st_nxt.window_reset = valid & i_halt_mode & ~st_r.halt_prev
                        & st_r.opt.watchdog_hse_option[obcfg_pkg::WINDOW_LP_BIT];
    for (int k = 0; k < 2; k++) begin
      if (!i_osc_en[k] || !valid) begin
        st_nxt.osc_cnt[k]   = '0;
        st_nxt.osc_ready[k] = 1'b0;
      end else if (!st_r.osc_ready[k] && st_r.osc_sync[k] && !st_r.osc_prev[k]) begin
        st_nxt.osc_cnt[k] = st_r.osc_cnt[k] + 13'h0001;
        if (st_r.osc_cnt[k] + 13'h0001 >= settle_target[k]) begin
          st_nxt.osc_ready[k] = 1'b1;
        end
      end
    end
    if (i_rst) begin
      st_nxt     = obcfg_pkg::STATE_RESET;
      st_nxt.opt = i_opt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_r <= st_nxt;
  end

  assign o_cfg_valid           = valid;
  assign o_opt_readback        = st_r.opt;
  assign o_readout_unprotected = valid && (st_r.opt.readout_protect_option == obcfg_pkg::READOUT_OPEN_CODE);
  assign o_boot_pages          = boot_pages;
  assign o_page_wr_protect     = st_r.wr_protect;
  assign o_indep_wdog.hw_start  = valid & st_r.opt.watchdog_hse_option[obcfg_pkg::INDEP_HW_BIT];
  assign o_indep_wdog.lowpower  = st_r.opt.watchdog_hse_option[obcfg_pkg::INDEP_LP_BIT];
  assign o_window_wdog.hw_start = valid & st_r.opt.watchdog_hse_option[obcfg_pkg::WINDOW_HW_BIT];
  assign o_window_wdog.lowpower = st_r.opt.watchdog_hse_option[obcfg_pkg::WINDOW_LP_BIT];
  assign o_indep_wdog_freeze   = st_r.indep_freeze;
  assign o_window_wdog_stop    = st_r.window_stop;
  assign o_window_wdog_reset   = st_r.window_reset;
  assign o_osc_ready           = st_r.osc_ready;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_readout_open_code: assert property (o_readout_unprotected
                                        |-> o_opt_readback.readout_protect_option == obcfg_pkg::READOUT_OPEN_CODE)
    else $error("readout opened without open code");
  a_readout_stays_on: assert property (o_opt_readback.readout_protect_option != obcfg_pkg::READOUT_OPEN_CODE
                                       |-> !o_readout_unprotected)
    else $error("readout opened by other code");
  a_boot_empty: assert property (o_cfg_valid && o_opt_readback.boot_area_size_option == obcfg_pkg::BOOT_NONE
                                 && $stable(o_opt_readback) ##1 $past(i_prog_unlocked) |-> o_page_wr_protect == '0)
    else $error("empty boot area still protects");
  a_boot_page0: assert property (o_opt_readback.boot_area_size_option == 8'h01 && o_cfg_valid
                                 |=> o_page_wr_protect[0] && o_boot_pages == 8'h01)
    else $error("page 0 not protected");
  a_boot_two: assert property (o_opt_readback.boot_area_size_option == 8'h02 && o_cfg_valid
                               |=> o_page_wr_protect[1:0] == 2'h3 && o_boot_pages == 8'h02)
    else $error("pages 0 and 1 not protected");
  a_boot_three: assert property (o_opt_readback.boot_area_size_option == 8'h03 && o_cfg_valid
                                 |=> o_page_wr_protect[2:0] == 3'h7 && o_boot_pages == 8'h03)
    else $error("pages 0 to 2 not protected");
  a_boot_all: assert property (o_opt_readback.boot_area_size_option >= 8'h7F && o_cfg_valid |=> &o_page_wr_protect)
    else $error("full boot area not protected");
  a_unlock_keys: assert property (o_cfg_valid && i_prog_unlocked && o_boot_pages < 8'h80
                                  |=> !o_page_wr_protect[PAGES-1])
    else $error("unlocked page outside boot area protected");
  a_wdog_start: assert property (o_cfg_valid
                                 |-> o_indep_wdog.hw_start == o_opt_readback.watchdog_hse_option[obcfg_pkg::INDEP_HW_BIT]
                                 && o_window_wdog.hw_start == o_opt_readback.watchdog_hse_option[obcfg_pkg::WINDOW_HW_BIT])
    else $error("watchdog start mode mismatch");
  a_indep_freeze: assert property (o_indep_wdog_freeze |-> $past(i_halt_mode) && o_indep_wdog.lowpower)
    else $error("independent watchdog frozen outside low-power halt");
  a_window_reset: assert property (o_window_wdog_reset |-> o_window_wdog.lowpower && !o_window_wdog_stop
                                   ##1 !o_window_wdog_reset)
    else $error("window watchdog halt reset wrong");
  a_fast_settle: assert property ($rose(o_osc_ready[0]) |-> st_r.osc_cnt[0] == settle_target[0])
    else $error("fast oscillator ready at wrong count");
  a_slow_settle: assert property ($rose(o_osc_ready[1]) |-> st_r.osc_cnt[1] == settle_target[1])
    else $error("slow oscillator ready at wrong count");
  a_load_first: assert property ((o_indep_wdog.hw_start || o_window_wdog.hw_start || o_osc_ready != 2'h0)
                                 |-> o_cfg_valid)
    else $error("settings used before load");

  // load stays valid, boot decode and key lock
  a_valid_holds: assert property (o_cfg_valid |=> o_cfg_valid)
    else $error("configuration valid dropped without reset");
  a_boot_none_pages: assert property (o_cfg_valid
                                      && o_opt_readback.boot_area_size_option == obcfg_pkg::BOOT_NONE
                                      |-> o_boot_pages == obcfg_pkg::BOOT_NONE)
    else $error("empty boot area has pages");
  a_boot_all_pages: assert property (o_cfg_valid
                                     && o_opt_readback.boot_area_size_option >= obcfg_pkg::BOOT_ALL_FROM
                                     |-> o_boot_pages == obcfg_pkg::BOOT_ALL_PAGES)
    else $error("full boot area page count wrong");
  a_key_lock: assert property (o_cfg_valid && !i_prog_unlocked
                               |=> &o_page_wr_protect)
    else $error("locked keys leave a page writable");

  // halt behaviour of both watchdogs
  a_freeze_set: assert property (o_cfg_valid && i_halt_mode && o_indep_wdog.lowpower
                                 |=> o_indep_wdog_freeze)
    else $error("independent watchdog not frozen in halt");
  a_freeze_clear: assert property (!i_halt_mode
                                   |=> !o_indep_wdog_freeze)
    else $error("independent watchdog frozen outside halt");
  a_window_stop_set: assert property (o_cfg_valid && i_halt_mode && !o_window_wdog.lowpower
                                      |=> o_window_wdog_stop && !o_window_wdog_reset)
    else $error("window watchdog not stopped in halt");
  a_window_reset_set: assert property (o_cfg_valid && $rose(i_halt_mode) && o_window_wdog.lowpower
                                       |=> o_window_wdog_reset)
    else $error("window watchdog reset missing on halt entry");

  // oscillator ready drops when disabled
  a_fast_ready_off: assert property (!i_osc_en[obcfg_pkg::OSC_FAST]
                                     |=> !o_osc_ready[obcfg_pkg::OSC_FAST])
    else $error("fast oscillator ready while disabled");
  a_slow_ready_off: assert property (!i_osc_en[obcfg_pkg::OSC_SLOW]
                                     |=> !o_osc_ready[obcfg_pkg::OSC_SLOW])
    else $error("slow oscillator ready while disabled");

endmodule : obcfg_decoder

// ==== test/obcfg_decoder_tb.sv ====
// self-checking testbench for the option byte decoder
`timescale 1ns/100ps
module obcfg_decoder_tb;
  logic                  i_clk_sys = 1'b0;
  logic                  i_rst = 1'b1;
  obcfg_pkg::obcfg_opt_t i_opt = '0;
  logic                  i_prog_unlocked = 1'b1;
  logic                  i_halt_mode = 1'b0;
  logic [1:0]            i_osc_en = 2'h0;
  logic [1:0]            i_osc_clk = 2'h0;
  logic                  o_cfg_valid;
  obcfg_pkg::obcfg_opt_t o_opt_readback;
  logic                  o_readout_unprotected;
  logic [7:0]            o_boot_pages;
  logic [127:0]          o_page_wr_protect;
  obcfg_pkg::obcfg_wdog_t o_indep_wdog;
  obcfg_pkg::obcfg_wdog_t o_window_wdog;
  logic                  o_indep_wdog_freeze;
  logic                  o_window_wdog_stop;
  logic                  o_window_wdog_reset;
  logic [1:0]            o_osc_ready;
  int                    mismatches = 0;
  int                    checks_done = 0;

  obcfg_decoder #(.PAGES(128)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_opt(i_opt),
    .i_prog_unlocked(i_prog_unlocked), .i_halt_mode(i_halt_mode), .i_osc_en(i_osc_en), .i_osc_clk(i_osc_clk),
    .o_cfg_valid(o_cfg_valid), .o_opt_readback(o_opt_readback), .o_readout_unprotected(o_readout_unprotected),
    .o_boot_pages(o_boot_pages), .o_page_wr_protect(o_page_wr_protect), .o_indep_wdog(o_indep_wdog),
    .o_window_wdog(o_window_wdog), .o_indep_wdog_freeze(o_indep_wdog_freeze),
    .o_window_wdog_stop(o_window_wdog_stop), .o_window_wdog_reset(o_window_wdog_reset), .o_osc_ready(o_osc_ready));

  always #2 i_clk_sys = ~i_clk_sys;

  task automatic chk_vec(input string name, input logic [127:0] exp, input logic [127:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_vec

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_vec(name, {127'h0, exp}, {127'h0, got});
  endtask : chk_bit

  // reset held 8 cycles with the option image presented, then released
  task automatic load(input obcfg_pkg::obcfg_opt_t opt);
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    i_opt = opt;
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    i_opt = ~opt;
    @(negedge i_clk_sys);
    chk_bit("cfg_valid", 1'b1, o_cfg_valid);
    chk_vec("opt_readback", {88'h0, opt}, {88'h0, o_opt_readback});
  endtask : load

  task automatic scen_boot();
    logic [7:0]   sizes [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7F, 8'hFF};
    logic [7:0]   pages [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h80};
    logic [7:0]   rops [6]  = '{8'hAA, 8'hAB, 8'h00, 8'h55, 8'hFF, 8'hAA};
    logic [127:0] mask;
    for (int i = 0; i < 6; i++) begin
      load('{rops[i], sizes[i], 8'h00, 8'h00, 8'h00});
      chk_bit("readout_unprotected", rops[i] == 8'hAA, o_readout_unprotected);
      chk_bit("readout_unprotected", rops[i] == 8'hAA, o_readout_unprotected);
      chk_vec("boot_pages", {120'h0, pages[i]}, {120'h0, o_boot_pages});
      for (int p = 0; p < 128; p++) mask[p] = (p < pages[i]);
      chk_vec("page_wr_protect", mask, o_page_wr_protect);
      i_prog_unlocked = 1'b0;
      @(negedge i_clk_sys);
      chk_vec("page_wr_protect_locked", {128{1'b1}}, o_page_wr_protect);
      i_prog_unlocked = 1'b1;
      @(negedge i_clk_sys);
      chk_vec("page_wr_protect_unlocked", mask, o_page_wr_protect);
    end
  endtask : scen_boot

  task automatic scen_wdog();
    logic [7:0] wd;
    for (int i = 0; i < 4; i++) begin
      wd = (i == 0) ? 8'h00 : (i == 1) ? 8'h05 : (i == 2) ? 8'h0A : 8'h0F;
      load('{8'h00, 8'h00, 8'h00, wd, 8'h00});
      chk_vec("indep_wdog", {126'h0, wd[0], wd[1]}, {126'h0, o_indep_wdog});
      chk_vec("window_wdog", {126'h0, wd[2], wd[3]}, {126'h0, o_window_wdog});
      i_halt_mode = 1'b1;
      @(negedge i_clk_sys);
      chk_bit("indep_freeze", wd[1], o_indep_wdog_freeze);
      chk_bit("window_stop", ~wd[3], o_window_wdog_stop);
      chk_bit("window_reset", wd[3], o_window_wdog_reset);
      @(negedge i_clk_sys);
      chk_bit("window_reset_end", 1'b0, o_window_wdog_reset);
      chk_bit("indep_freeze_hold", wd[1], o_indep_wdog_freeze);
      i_halt_mode = 1'b0;
      @(negedge i_clk_sys);
      chk_bit("indep_freeze_off", 1'b0, o_indep_wdog_freeze);
      chk_bit("window_stop_off", 1'b0, o_window_wdog_stop);
    end
  endtask : scen_wdog

  task automatic osc_pulse(input int k);
    i_osc_clk[k] = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_osc_clk[k] = 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask : osc_pulse

  task automatic scen_osc(input int k, input logic [1:0] code);
    int target;
    target = (code == 2'h0) ? 1 : (code == 2'h1) ? 16 : (code == 2'h2) ? 512 : 4096;
    load('{8'h00, 8'h00, 8'h00, (k == 0) ? {2'h0, code, 4'h0} : 8'h00, (k == 1) ? {6'h0, code} : 8'h00});
    i_osc_en[k] = 1'b1;
    for (int n = 1; n < target; n++) osc_pulse(k);
    chk_bit("osc_ready_early", 1'b0, o_osc_ready[k]);
    i_osc_clk[k] = 1'b1;
    for (int w = 0; w < 8 && o_osc_ready[k] !== 1'b1; w++) @(negedge i_clk_sys);
    i_osc_clk[k] = 1'b0;
    chk_bit("osc_ready", 1'b1, o_osc_ready[k]);
    i_osc_en[k] = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk_bit("osc_ready_off", 1'b0, o_osc_ready[k]);
  endtask : scen_osc

  task automatic close_out();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  initial begin
    scen_boot();
    scen_wdog();
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) scen_osc(k, c[1:0]);
    end
    close_out();
  end
endmodule : obcfg_decoder_tb
